// [rtl/mfirq_flag_reg.sv]
`timescale 1ns/1ps
`include "mfirq_map.svh"
// One eight-bit flag/enable register: flags 7..4 pair with enables 3..0.
module mfirq_flag_reg
    import mfirq_pkg::*;
#(
    parameter logic [7:0] IMPL = 8'hFF
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic writeEn,
    input wire logic [7:0] writeData,
    input wire logic [3:0] events,
    output logic [7:0] value,
    output logic pending
);
    logic [7:0] next_value;
    logic [7:0] stored;

    // A write replaces the byte, but a same-cycle event still sets its flag.
    always_comb begin
        next_value = stored;
        if (writeEn) begin
            next_value = writeData;
        end
        next_value[7:4] = next_value[7:4] | events;
        next_value = next_value & IMPL;
    end

    // Flags are recorded regardless of the enables.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stored <= `MFIRQ_RST_REG;
        end else begin
            stored <= next_value;
        end
    end

    assign value = stored;
    // Only enabled flags count toward the request.
    assign pending = |(stored[7:4] & stored[3:0]);
endmodule // mfirq_flag_reg

// [rtl/mfirq_map.svh]
`ifndef MFIRQ_MAP_SVH
`define MFIRQ_MAP_SVH
// Word offsets on the register bus (byte address = index * 4).
`define MFIRQ_IDX_TMR2 3'h0
`define MFIRQ_IDX_SER 3'h1
`define MFIRQ_IDX_PAIR 3'h2
`define MFIRQ_IDX_STAT 3'h3
`define MFIRQ_IDX_MASK 3'h4
// Reset values.
`define MFIRQ_RST_REG 8'h00
`define MFIRQ_RST_STAT 3'h0
// Mask of implemented bits in the first register.
`define MFIRQ_TMR2_IMPL 8'h33
// Field positions: flags in 7..4, enables in 3..0.
`define MFIRQ_FLAG_LSB 4
`define MFIRQ_EN_LSB 0
`endif

// [rtl/mfirq_pkg.sv]
package mfirq_pkg;
    typedef struct packed {
        logic [2:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } mfirq_bus_req_t;
    typedef enum logic [1:0] {
        MFIRQ_IDLE = 2'b01,
        MFIRQ_DONE = 2'b10
    } mfirq_state_t;
endpackage

// [rtl/mfirq_regs.sv]
`timescale 1ns/1ps
`include "mfirq_map.svh"
// How it works
// - Unimplemented first-register bits read zero.
// - Timer C compare-A match sets bit five.
// - Bit one enables timer C compare-A.
// - Bit zero enables period; flag at four.
// - Serial flag bit7, SPI bit6, enables 3,2.
// - EEPROM flag bit five, enable bit one.
// - Low-voltage flag bit4, enable bit0; reset zero.
// - Flags record always; interrupt only if enabled.
module mfirq_regs
    import mfirq_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ptimer_c_cmpa_flag,
    input wire logic ptimer_c_cmpp_flag,
    input wire logic serial_module_flag,
    input wire logic spi_req_flag,
    input wire logic eeprom_req_flag,
    input wire logic lowvolt_req_flag,
    input wire logic stimer_c_cmpa_flag,
    input wire logic stimer_c_cmpp_flag,
    input wire logic ptimer_d_cmpa_flag,
    input wire logic ptimer_d_cmpp_flag,
    output logic mfRequest,
    output logic irq
);
    mfirq_bus_req_t req;
    mfirq_state_t state;
    logic [7:0] regVal [3];
    logic [2:0] pendVec;
    logic [3:0] evts [3];
    logic [2:0] status;
    logic [2:0] mask;
    logic accept;
    logic wrHit [3];

    assign req = '{address: avs_address, read: avs_read, write: avs_write, writedata: avs_writedata};
    // Each request is accepted in IDLE and answered in the following cycle.
    assign accept = (state == MFIRQ_IDLE) && (req.read || req.write);

    assign evts[0] = {2'b00, ptimer_c_cmpa_flag, ptimer_c_cmpp_flag};
    assign evts[1] = {serial_module_flag, spi_req_flag, eeprom_req_flag, lowvolt_req_flag};
    assign evts[2] = {stimer_c_cmpa_flag, stimer_c_cmpp_flag, ptimer_d_cmpa_flag, ptimer_d_cmpp_flag};

    // The three flag registers are one generate loop; only slice 0 masks its byte to the implemented bits.
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_reg
            assign wrHit[g] = accept && req.write && (req.address == 3'(g));
            mfirq_flag_reg #(
                .IMPL(g == 0 ? `MFIRQ_TMR2_IMPL : 8'hFF)
            ) u_reg (
                .clk(clk),
                .sys_rst(sys_rst),
                .writeEn(wrHit[g]),
                .writeData(req.writedata[7:0]),
                .events(evts[g]),
                .value(regVal[g]),
                .pending(pendVec[g])
            );
        end
    endgenerate

    // Handshake: waitrequest is high except in the answering cycle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= MFIRQ_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            unique case (state)
                MFIRQ_IDLE: begin
                    if (accept) begin
                        state <= MFIRQ_DONE;
                        avs_waitrequest <= 1'b0;
                    end
                end
                MFIRQ_DONE: begin
                    state <= MFIRQ_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Read data is captured on accept; unmapped addresses read zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (accept && req.read) begin
            unique case (req.address)
                `MFIRQ_IDX_TMR2: avs_readdata <= {24'h000000, regVal[0]};
                `MFIRQ_IDX_SER: avs_readdata <= {24'h000000, regVal[1]};
                `MFIRQ_IDX_PAIR: avs_readdata <= {24'h000000, regVal[2]};
                `MFIRQ_IDX_STAT: avs_readdata <= {29'h00000000, status};
                `MFIRQ_IDX_MASK: avs_readdata <= {29'h00000000, mask};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Sticky per-register pending status; a read clears it, but new pending wins.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status <= `MFIRQ_RST_STAT;
        end else if (accept && req.read && req.address == `MFIRQ_IDX_STAT) begin
            status <= pendVec;
        end else begin
            status <= status | pendVec;
        end
    end

    // Mask register of the same layout as status.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mask <= `MFIRQ_RST_STAT;
        end else if (accept && req.write && req.address == `MFIRQ_IDX_MASK) begin
            mask <= req.writedata[2:0];
        end
    end

    // Summary request follows enabled flags directly, one register stage late.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mfRequest <= 1'b0;
            irq <= 1'b0;
        end else begin
            mfRequest <= |pendVec;
            irq <= |(status & mask);
        end
    end
endmodule // mfirq_regs

// [test/mfirq_asserts.sv]
`timescale 1ns/1ps
// Bus handshake and request outputs, judged from the ports alone.
module mfirq_asserts(
    input logic clk,
    input logic sys_rst,
    input logic [2:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_readdata,
    input logic avs_waitrequest,
    input logic mfRequest,
    input logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence sAns; avs_read && !avs_waitrequest; endsequence
    AST_RST: assert property ($fell(sys_rst) |-> avs_waitrequest && !irq && !mfRequest)
        else $error("busy after reset");
    AST_ANS: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
        else $error("no answer");
    AST_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("long answer");
    AST_RSV: assert property (sAns ##0 avs_address == 3'h0 |-> (avs_readdata & 32'hFFFFFFCC) == 32'h0)
        else $error("reserved bit set");
    AST_HI: assert property (sAns |-> avs_readdata[31:8] == 24'h0)
        else $error("high byte set");
    AST_HOLD: assert property (!avs_read [*2] |-> $stable(avs_readdata))
        else $error("data moved");
    AST_MF: assert property ($fell(mfRequest) |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
        else $error("request fell");
    AST_IRQ: assert property ($fell(irq) |-> $past(avs_read || avs_write) || $past(avs_read || avs_write, 2)
        || $past(avs_read || avs_write, 3)) else $error("irq fell");
endmodule // mfirq_asserts
bind mfirq_regs mfirq_asserts mfirq_asserts_i(.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .mfRequest, .irq);

// [test/mfirq_evsrc.sv]
`timescale 1ns/1ps
module mfirq_evsrc(
    input logic clk,
    input logic go,
    input logic [3:0] sel,
    output logic [9:0] ev
);
    // Sources pulse for one clock only, so the flag itself must hold the event.
    always_ff @(posedge clk) begin
        ev <= go ? 10'h001 << sel : 10'h000;
    end
endmodule // mfirq_evsrc

// [test/tb_mfirq_regs.sv]
`timescale 1ns/1ps
module tb_mfirq_regs;
    logic clk = 0, rst = 1, rd = 0, wr = 0, go = 0, waitReq, mfReq, irq;
    logic [2:0] addr = 3'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [9:0] ev;
    int errors = 0, cmp_count = 0, cyc = 0;
    // Per event line: register index above, expected flag byte below.
    logic [10:0] row [10] = '{11'h020, 11'h010, 11'h180, 11'h140, 11'h120, 11'h110, 11'h280, 11'h240, 11'h220, 11'h210};
    mfirq_regs mfirq_regs_i(.clk(clk), .sys_rst(rst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitReq), .ptimer_c_cmpa_flag(ev[0]),
        .ptimer_c_cmpp_flag(ev[1]), .serial_module_flag(ev[2]), .spi_req_flag(ev[3]), .eeprom_req_flag(ev[4]),
        .lowvolt_req_flag(ev[5]), .stimer_c_cmpa_flag(ev[6]), .stimer_c_cmpp_flag(ev[7]),
        .ptimer_d_cmpa_flag(ev[8]), .ptimer_d_cmpp_flag(ev[9]), .mfRequest(mfReq), .irq(irq));
    mfirq_evsrc mfirq_evsrc_i(.clk(clk), .go(go), .sel(sel), .ev(ev));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // The run needs far fewer cycles; a stuck handshake ends here.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // The request stands until waitrequest is sampled low.
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        {rd, wr, addr, wdata} <= {!w, w, a, 24'h0, d};
        do @(posedge clk); while (waitReq !== 1'b0);
        q = rdata;
        {rd, wr} <= 2'b00;
    endtask
    task automatic pulse(input logic [3:0] i);
        {sel, go} <= {i, 1'b1};
        @(posedge clk) go <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int r = 0; r < 5; r++) begin
            acc(0, r[2:0], 8'h00);
            chk("reset", 32'h0, q);
        end
        acc(1, 3'h0, 8'hFF);
        acc(0, 3'h0, 8'h00);
        chk("reg0", 32'h33, q);
        acc(1, 3'h0, 8'h00);
        acc(0, 3'h6, 8'h00);
        chk("unmapped", 32'h0, q);
        for (int i = 0; i < 10; i++) begin
            pulse(i[3:0]);
            acc(0, row[i][10:8], 8'h00);
            chk("flag", {24'h0, row[i][7:0]}, q);
            chk("masked", 32'h0, {31'h0, mfReq});
            acc(1, row[i][10:8], row[i][7:0] | row[i][7:4]);
            repeat (2) @(posedge clk);
            chk("request", 32'h1, {31'h0, mfReq});
            acc(1, row[i][10:8], 8'h00);
        end
        acc(1, 3'h0, 8'h02);
        pulse(4'h0);
        chk("irq off", 32'h0, {31'h0, irq});
        acc(1, 3'h4, 8'h01);
        repeat (2) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        acc(1, 3'h0, 8'h00);
        acc(0, 3'h3, 8'h00);
        chk("status", 32'h7, q);
        repeat (2) @(posedge clk);
        chk("irq clear", 32'h0, {31'h0, irq});
        end_of_test();
    end
endmodule // tb_mfirq_regs
